// ### lsb_exec_unit.sv
/*
  execution of and, shift, bit and relative-jump operations of an 8-bit core.
  assumes one clock, operations offered on a valid/ready pair from the decoder.
*/
// Functional notes
// RULE1: and literal into accumulator, zero flag only
// RULE2: and register, target select picks destination
// RULE3: shift right keeps msb, bit0 to carry
// RULE4: shift updates carry and zero, selectable target
// RULE5: bit clear zeroes one bit, no flags
// RULE6: bit set forces one bit, no flags
// RULE7: jump by sign-extended literal, two cycles
// RULE8: jump by unsigned accumulator, two cycles
// RULE9: skip next instruction when tested bit zero
// RULE10: pc change or true test adds nop
// RULE11: zero flag set exactly when result zero
module lsb_exec_unit
  import lsb_pkg::*;
#(
  parameter int PCW = PC_W
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // operation issue
  input  wire logic                op_valid,
  input  wire lsb_op_t             op_code,
  input  wire logic [FADDR_W-1:0]  op_addr,
  input  wire logic                op_dest,
  input  wire logic [BITSEL_W-1:0] op_bit,
  input  wire logic [LIT_W-1:0]    op_lit,
  output logic                     op_ready,
  // loads from the rest of the core, idle only
  input  wire logic                ext_acc_we,
  input  wire logic [DATA_W-1:0]   ext_acc_data,
  input  wire logic                ext_fr_we,
  input  wire logic [FADDR_W-1:0]  ext_fr_addr,
  input  wire logic [DATA_W-1:0]   ext_fr_data,
  // core state
  output logic [DATA_W-1:0]        acc,
  output logic [PCW-1:0]           pc,
  output logic                     zero_flag,
  output logic                     carry_flag,
  output logic                     nop_cycle
);

  function automatic logic [DATA_W-1:0] bit_mask(input logic [BITSEL_W-1:0] b);
    bit_mask = DATA_W'(1) << b;
  endfunction

  lsb_fr_if fr ();

  lsb_file_mem #(.DEPTH(FR_DEPTH)) u_mem (
    .clock (clock),
    .fr    (fr.mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state

  lsb_state_t            state_r, state_nxt;
  lsb_op_t               op_r, op_nxt;
  logic [FADDR_W-1:0]    addr_r, addr_nxt;
  logic                  dest_r, dest_nxt;
  logic [BITSEL_W-1:0]   bit_r, bit_nxt;
  logic [LIT_W-1:0]      lit_r, lit_nxt;
  logic [DATA_W-1:0]     acc_r, acc_nxt;
  logic [PCW-1:0]        pc_r, pc_nxt;
  logic                  zero_r, zero_nxt;
  logic                  carry_r, carry_nxt;
  logic                  ready_r, ready_nxt;
  logic                  nop_r, nop_nxt;
  logic                  we_c;
  logic [FADDR_W-1:0]    waddr_c;
  logic [DATA_W-1:0]     wdata_c;
  logic [DATA_W-1:0]     res_c;
  logic                  two_c;
  logic [DATA_W-1:0]     src;

  assign src = fr.rdata;

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    dest_nxt  = dest_r;
    bit_nxt   = bit_r;
    lit_nxt   = lit_r;
    acc_nxt   = acc_r;
    pc_nxt    = pc_r;
    zero_nxt  = zero_r;
    carry_nxt = carry_r;
    ready_nxt = ready_r;
    nop_nxt   = 1'b0;
    we_c      = 1'b0;
    waddr_c   = addr_r;
    wdata_c   = 8'h00;
    res_c     = 8'h00;
    two_c     = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (op_valid) begin
          op_nxt    = op_code;
          addr_nxt  = op_addr;
          dest_nxt  = op_dest;
          bit_nxt   = op_bit;
          lit_nxt   = op_lit;
          ready_nxt = 1'b0;
          state_nxt = S_EXEC;
        end else begin
          // outside loads are taken only in a free idle cycle; a load offered with an operation or while busy is dropped
          if (ext_acc_we) begin
            acc_nxt = ext_acc_data;
          end
          if (ext_fr_we) begin
            we_c    = 1'b1;
            waddr_c = ext_fr_addr;
            wdata_c = ext_fr_data;
          end
        end
      end
      S_EXEC: begin
        pc_nxt = pc_r + PCW'(PC_STEP);
        case (op_r)
          and_literal_to_acc: begin
            res_c    = acc_r & lit_r[DATA_W-1:0]; // RULE1
            acc_nxt  = res_c;
            zero_nxt = (res_c == 8'h00); // RULE11
          end
          and_acc_with_reg, arith_shift_right: begin
            if (op_r == arith_shift_right) begin
              res_c     = {src[DATA_W-1], src[DATA_W-1:1]}; // RULE3
              carry_nxt = src[0]; // RULE4
            end else begin
              res_c = acc_r & src; // RULE2
            end
            zero_nxt = (res_c == 8'h00); // RULE11
            if (dest_r) begin
              we_c    = 1'b1;
              wdata_c = res_c;
            end else begin
              acc_nxt = res_c;
            end
          end
          bit_clear_reg: begin
            we_c    = 1'b1;
            wdata_c = src & ~bit_mask(bit_r); // RULE5
          end
          bit_set_reg: begin
            we_c    = 1'b1;
            wdata_c = src | bit_mask(bit_r); // RULE6
          end
          pc_relative_jump_literal: begin
            pc_nxt = pc_r + PCW'(PC_STEP) + {{(PCW-LIT_W){lit_r[LIT_W-1]}}, lit_r}; // RULE7
            two_c  = 1'b1;
          end
          pc_relative_jump_acc: begin
            pc_nxt = pc_r + PCW'(PC_STEP) + PCW'(acc_r); // RULE8
            two_c  = 1'b1;
          end
          default: begin
            // discarded instruction: pc steps over it
            if (!src[bit_r]) begin
              pc_nxt = pc_r + PCW'(PC_SKIP); // RULE9
              two_c  = 1'b1;
            end
          end
        endcase
        if (two_c) begin
          state_nxt = S_NOP; // RULE10
          nop_nxt   = 1'b1;
        end else begin
          state_nxt = S_IDLE;
          ready_nxt = 1'b1;
        end
      end
      S_NOP: begin
        state_nxt = S_IDLE;
        ready_nxt = 1'b1;
      end
      default: begin
        state_nxt = S_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      op_r    <= and_literal_to_acc;
      addr_r  <= '0;
      dest_r  <= 1'b0;
      bit_r   <= '0;
      lit_r   <= '0;
      acc_r   <= ACC_RST;
      pc_r    <= PCW'(PC_RST);
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
      ready_r <= 1'b1;
      nop_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      dest_r  <= dest_nxt;
      bit_r   <= bit_nxt;
      lit_r   <= lit_nxt;
      acc_r   <= acc_nxt;
      pc_r    <= pc_nxt;
      zero_r  <= zero_nxt;
      carry_r <= carry_nxt;
      ready_r <= ready_nxt;
      nop_r   <= nop_nxt;
    end
  end

  // read address follows the offered operation so data is ready in exec
  assign fr.raddr = (state_r == S_IDLE) ? op_addr : addr_r;
  assign fr.we    = we_c;
  assign fr.waddr = waddr_c;
  assign fr.wdata = wdata_c;

  assign op_ready   = ready_r;
  assign acc        = acc_r;
  assign pc         = pc_r;
  assign zero_flag  = zero_r;
  assign carry_flag = carry_r;
  assign nop_cycle  = nop_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic ex_c;
  assign ex_c = (state_r == S_EXEC);

  a_and_lit_acc: assert property (ex_c && op_r == and_literal_to_acc // RULE1
    |=> acc_r == $past(acc_r & lit_r[7:0]) && $stable(carry_r))
    else $error("literal and result wrong");
  a_and_reg_dest: assert property (ex_c && op_r == and_acc_with_reg && dest_r // RULE2
    |-> we_c && wdata_c == (acc_r & src) ##1 $stable(acc_r))
    else $error("register and not written back");
  a_shift_acc: assert property (ex_c && op_r == arith_shift_right && !dest_r // RULE3
    |=> acc_r == {$past(src[7]), $past(src[7:1])} && carry_r == $past(src[0]))
    else $error("shift result or carry wrong");
  a_shift_flags: assert property (ex_c && op_r == arith_shift_right && dest_r // RULE4
    |-> we_c ##1 zero_r == ($past(src[7:1]) == 7'h00 && !$past(src[7])))
    else $error("shift to register wrong");
  a_bit_clear: assert property (ex_c && op_r == bit_clear_reg // RULE5
    |-> we_c && !wdata_c[bit_r] && (wdata_c | bit_mask(bit_r)) == (src | bit_mask(bit_r))
    ##1 $stable(zero_r) && $stable(carry_r))
    else $error("bit clear wrong");
  a_bit_set: assert property (ex_c && op_r == bit_set_reg // RULE6
    |-> we_c && wdata_c == (src | bit_mask(bit_r)) ##1 $stable(zero_r))
    else $error("bit set wrong");
  a_jump_lit: assert property (ex_c && op_r == pc_relative_jump_literal // RULE7
    |=> nop_r && pc_r == $past(pc_r) + 15'h0001 + {{6{$past(lit_r[8])}}, $past(lit_r)} ##1 op_ready)
    else $error("literal jump wrong");
  a_jump_acc: assert property (ex_c && op_r == pc_relative_jump_acc // RULE8
    |=> pc_r == $past(pc_r) + 15'h0001 + {7'h00, $past(acc_r)} && $stable(zero_r))
    else $error("accumulator jump wrong");
  a_skip_low: assert property (ex_c && op_r == test_bit_skip_if_low && !src[bit_r] // RULE9
    |=> state_r == S_NOP && pc_r == $past(pc_r) + 15'h0002 ##1 state_r == S_IDLE)
    else $error("skip not taken");
  a_nop_quiet: assert property (state_r == S_NOP |-> !we_c && !ready_r ##1 $stable(acc_r)) // RULE10
    else $error("second cycle not a nop");
  a_zero_flag: assert property (ex_c && op_r == and_literal_to_acc // RULE11
    |=> zero_r == (acc_r == 8'h00))
    else $error("zero flag wrong");

  c_jump_taken: cover property (ex_c && op_r == pc_relative_jump_literal ##2 op_ready);
  c_skip_taken: cover property (ex_c && op_r == test_bit_skip_if_low && !src[bit_r]);
  c_shift_reg:  cover property (ex_c && op_r == arith_shift_right && dest_r);
  c_zero_set:   cover property (ex_c && op_r == and_acc_with_reg ##1 zero_r);

endmodule

// ### lsb_pkg.sv
/*
  package of the execution block: operation codes, widths, reset values.
  assumes nothing; imported by the memory, the interface and the top module.
*/
package lsb_pkg;

  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int LIT_W    = 9;
  localparam int BITSEL_W = 3;
  localparam int PC_W     = 15;
  localparam int FR_DEPTH = 128;

  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [14:0] PC_RST  = 15'h0000;

  // pc steps: plain advance, and advance past a discarded instruction
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [14:0] PC_SKIP = 15'h0002;

  typedef enum logic [2:0] {
    and_literal_to_acc       = 3'h0,
    and_acc_with_reg         = 3'h1,
    arith_shift_right        = 3'h2,
    bit_clear_reg            = 3'h3,
    bit_set_reg              = 3'h4,
    pc_relative_jump_literal = 3'h5,
    pc_relative_jump_acc     = 3'h6,
    test_bit_skip_if_low     = 3'h7
  } lsb_op_t;

  // gray along idle -> exec -> nop
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_EXEC = 2'h1,
    S_NOP  = 2'h3
  } lsb_state_t;

endpackage

// ### lsb_fr_if.sv
/*
  interface between the execution block and its file register memory.
  assumes both ends share one clock; read data is registered in the memory.
*/
interface lsb_fr_if;
  import lsb_pkg::*;

  logic                we;
  logic [FADDR_W-1:0]  waddr;
  logic [DATA_W-1:0]   wdata;
  logic [FADDR_W-1:0]  raddr;
  logic [DATA_W-1:0]   rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### lsb_file_mem.sv
/*
  file register memory: one write port, one read port with registered data.
  assumes a single clock; contents are not reset, software must write first.
*/
module lsb_file_mem
  import lsb_pkg::*;
#(
  parameter int DEPTH = FR_DEPTH
) (
  // clock
  input wire logic clock,
  // memory port
  lsb_fr_if.mem    fr
);

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rdata_r;

  always_ff @(posedge clock) begin
    if (fr.we) begin
      mem_q[fr.waddr] <= fr.wdata;
    end
    // old data on a same-address write; in exec the block reads and writes the same word addr_r together
    rdata_r <= mem_q[fr.raddr];
  end

  assign fr.rdata = rdata_r;

endmodule

// ### lsb_exec_unit_tb.sv
/*
  self-checking bench of the execution block: one task per scenario.
  assumes the block holds its own file registers, seeded through the loads.
*/
module lsb_exec_unit_tb
  import lsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clock = 0, rst_n = 0;
  logic             op_valid = 0, op_dest = 0, op_ready, nop_cycle;
  lsb_op_t          op_code = and_literal_to_acc;
  logic [6:0]       op_addr = 0, ext_fr_addr = 0;
  logic [2:0]       op_bit = 0;
  logic [8:0]       op_lit = 0;
  logic             ext_acc_we = 0, ext_fr_we = 0;
  logic [7:0]       ext_acc_data = 0, ext_fr_data = 0, acc;
  logic [14:0]      pc, exp_pc = 0;
  logic             zero_flag, carry_flag, ez = 0, ec = 0;
  int               err_total = 0, tests_run = 0;

  lsb_exec_unit #(.PCW(PC_W)) i_dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_dest(op_dest), .op_bit(op_bit), .op_lit(op_lit),
    .op_ready(op_ready), .ext_acc_we(ext_acc_we), .ext_acc_data(ext_acc_data),
    .ext_fr_we(ext_fr_we), .ext_fr_addr(ext_fr_addr), .ext_fr_data(ext_fr_data), .acc(acc),
    .pc(pc), .zero_flag(zero_flag), .carry_flag(carry_flag), .nop_cycle(nop_cycle));

  always #25 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one op; pc step, cycle count, nop and both flags judged against the model
  task automatic op(input lsb_op_t c, input logic [6:0] a, input logic d, input logic [2:0] b,
                    input logic [8:0] k, input logic [14:0] step, input logic two);
    int   n;
    logic saw;
    n = 1;
    saw = 0;
    @(negedge clock);
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    op_valid = 1; op_code = c; op_addr = a; op_dest = d; op_bit = b; op_lit = k;
    @(negedge clock);
    op_valid = 0;
    n = 1;
    while (op_ready !== 1'b1 && n < 20) begin
      if (nop_cycle === 1'b1) saw = 1;
      @(negedge clock);
      n++;
    end
    exp_pc = exp_pc + step;
    chk(15'(n), two ? 15'h3 : 15'h2, "cycles");
    chk(15'(saw), 15'(two), "nop");
    chk(pc, exp_pc, "pc");
    chk(15'(zero_flag), 15'(ez), "zero");
    chk(15'(carry_flag), 15'(ec), "carry");
  endtask

  task automatic ld_acc(input logic [7:0] v);
    @(negedge clock);
    ext_acc_we = 1; ext_acc_data = v;
    @(negedge clock);
    ext_acc_we = 0;
  endtask

  task automatic ld_fr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clock);
    ext_fr_we = 1; ext_fr_addr = a; ext_fr_data = v;
    @(negedge clock);
    ext_fr_we = 0;
  endtask

  // read back through an and with all ones
  task automatic chk_fr(input logic [6:0] a, input logic [7:0] v);
    ld_acc(8'hff);
    ez = (v == 8'h00);
    op(and_acc_with_reg, a, 0, 0, 0, 1, 0);
    chk(15'(acc), 15'(v), "reg");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_shift();
    ld_acc(8'h33); ld_fr(7'h05, 8'h81);
    ec = 1; ez = 0;
    op(arith_shift_right, 7'h05, 1, 0, 0, 1, 0);
    chk(15'(acc), 15'h33, "acc kept");
    chk_fr(7'h05, 8'hc0);
    ld_fr(7'h7f, 8'h01);
    ez = 1;
    op(arith_shift_right, 7'h7f, 0, 0, 0, 1, 0);
    chk(15'(acc), 15'h00, "asr");
    ld_fr(7'h7f, 8'h02);
    ec = 0; ez = 0;
    op(arith_shift_right, 7'h7f, 0, 0, 0, 1, 0);
    chk(15'(acc), 15'h01, "asr");
    ec = 1;
    ld_fr(7'h7f, 8'h01);
    ez = 1;
    op(arith_shift_right, 7'h7f, 1, 0, 0, 1, 0);
    $display("t_shift done");
  endtask

  task automatic t_and();
    ld_acc(8'ha5);
    ez = 0;
    op(and_literal_to_acc, 0, 0, 0, 9'h00f, 1, 0);
    chk(15'(acc), 15'h05, "andl");
    ld_acc(8'ha5);
    ez = 1;
    op(and_literal_to_acc, 0, 1, 0, 9'h05a, 1, 0);
    chk(15'(acc), 15'h00, "andl");
    ld_fr(7'h00, 8'h3c); ld_acc(8'hc3);
    op(and_acc_with_reg, 7'h00, 1, 0, 0, 1, 0);
    chk(15'(acc), 15'hc3, "acc kept");
    chk_fr(7'h00, 8'h00);
    ld_fr(7'h00, 8'h3c); ld_acc(8'hf0);
    ez = 0;
    op(and_acc_with_reg, 7'h00, 0, 0, 0, 1, 0);
    chk(15'(acc), 15'h30, "andw");
    $display("t_and done");
  endtask

  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      ld_fr(7'h09, 8'h00);
      op(bit_set_reg, 7'h09, 0, 3'(b), 0, 1, 0);
      chk_fr(7'h09, 8'h01 << b);
      ld_fr(7'h09, 8'hff);
      op(bit_clear_reg, 7'h09, 0, 3'(b), 0, 1, 0);
      chk_fr(7'h09, ~(8'h01 << b));
    end
    $display("t_bits done");
  endtask

  task automatic t_jump();
    op(pc_relative_jump_literal, 0, 0, 0, 9'h100, 15'h7f01, 1);
    op(pc_relative_jump_literal, 0, 0, 0, 9'h0ff, 15'h0100, 1);
    ld_acc(8'hff);
    op(pc_relative_jump_acc, 0, 0, 0, 0, 15'h0100, 1);
    ld_acc(8'h00);
    op(pc_relative_jump_acc, 0, 0, 0, 0, 15'h0001, 1);
    $display("t_jump done");
  endtask

  task automatic t_skip();
    ld_fr(7'h02, 8'h82);
    op(test_bit_skip_if_low, 7'h02, 0, 3'h1, 0, 1, 0);
    op(test_bit_skip_if_low, 7'h02, 0, 3'h7, 0, 1, 0);
    op(test_bit_skip_if_low, 7'h02, 0, 3'h0, 0, 2, 1);
    op(test_bit_skip_if_low, 7'h02, 0, 3'h6, 0, 2, 1);
    $display("t_skip done");
  endtask

  // reset in mid-run while idle; first op after release must run normally
  task automatic t_reset();
    ld_acc(8'h77);
    @(negedge clock);
    rst_n = 0;
    @(negedge clock);
    chk(pc, 15'h0000, "pc mid rst");
    chk({7'h00, acc}, 15'h0000, "acc mid rst");
    chk({11'h000, zero_flag, carry_flag, op_ready, nop_cycle}, 15'h0002, "ctl mid rst");
    rst_n = 1;
    exp_pc = 15'h0000;
    ec = 0;
    ez = 1;
    op(and_literal_to_acc, 0, 0, 0, 9'h0ff, 1, 0);
    chk(15'(acc), 15'h00, "andl after rst");
    $display("t_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // whole run is a few hundred cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #(50 * 20000);
    err_total++;
    results();
  end

  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1;
    chk(pc, 15'h0000, "pc rst");
    chk({7'h00, acc}, 15'h0000, "acc rst");
    chk({11'h000, zero_flag, carry_flag, op_ready, nop_cycle}, 15'h0002, "ctl rst");
    t_shift();
    t_and();
    t_bits();
    t_jump();
    t_skip();
    t_reset();
    results();
  end
endmodule
